/* File: hw/ldo_bank_pkg.sv */
// register map, field layout and reset values for the regulator bank
package ldo_bank_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CHANNELS = 3;
    localparam int CODE_W = 6;
    localparam logic [7:0] OFS_EIGHT_VOLTAGE = 8'h68;
    localparam logic [7:0] OFS_EIGHT_CONTROL = 8'h69;
    localparam logic [7:0] OFS_NINE_VOLTAGE = 8'h70;
    localparam logic [7:0] OFS_NINE_CONTROL = 8'h71;
    localparam logic [7:0] OFS_TEN_VOLTAGE = 8'h80;
    localparam logic [7:0] OFS_TEN_CONTROL = 8'h81;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_DISCHARGE = 2;
    localparam int BIT_FAULT_EN = 1;
    localparam int BIT_POWER_OK = 0;
    localparam logic [5:0] RST_CODE = 6'h00;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_DISCHARGE = 1'b0;
    localparam logic RST_FAULT_EN = 1'b0;
endpackage

/* File: hw/ldo_channel.sv */
// one regulator channel: storage of code and control bits, read views
`timescale 1ns/10ps
module ldo_channel
    import ldo_bank_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic wr_voltage_in,
    input wire logic wr_control_in,
    input wire logic [7:0] wdata_in,
    input wire logic power_ok_in,
    output logic [7:0] voltage_view_out,
    output logic [7:0] control_view_out,
    output logic [5:0] code_out,
    output logic enable_out,
    output logic discharge_out,
    output logic fault_en_out
);
    typedef struct packed {
        logic [5:0] code;
        logic enable;
        logic discharge;
        logic fault_en;
    } chan_state_t;

    chan_state_t state;
    chan_state_t next_state;

    always_comb begin
        next_state = state;
        if (wr_voltage_in) begin
            next_state.code = wdata_in[5:0];
        end
        if (wr_control_in) begin
            next_state.enable = wdata_in[BIT_ENABLE];
            next_state.discharge = wdata_in[BIT_DISCHARGE];
            next_state.fault_en = wdata_in[BIT_FAULT_EN];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '{RST_CODE, RST_ENABLE, RST_DISCHARGE, RST_FAULT_EN};
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    // reserved positions are constant zero
    assign voltage_view_out = {2'h0, state.code};
    assign control_view_out = {state.enable, 4'h0, state.discharge,
                               state.fault_en, power_ok_in};
    assign code_out = state.code;
    assign enable_out = state.enable;
    // discharge only while the channel is shut down
    assign discharge_out = state.discharge & ~state.enable;
    assign fault_en_out = state.fault_en;

    a_discharge_off: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        enable_out |-> !discharge_out)
        else $error("discharge active while channel enabled");
endmodule

/* File: hw/ldo_control_register_bank.sv */
// register bank for three regulator channels with a plain register port
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module ldo_control_register_bank
    import ldo_bank_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [2:0] power_ok_in,
    output logic [17:0] voltage_select_code_out,
    output logic [2:0] regulator_enable_out,
    output logic [2:0] shutdown_discharge_enable_out,
    output logic [2:0] fault_interrupt_enable_out
);
    typedef struct packed {
        logic [7:0] rdata;
    } bank_state_t;

    localparam logic [7:0] VOLT_OFS [CHANNELS] =
        '{OFS_EIGHT_VOLTAGE, OFS_NINE_VOLTAGE, OFS_TEN_VOLTAGE};
    localparam logic [7:0] CTRL_OFS [CHANNELS] =
        '{OFS_EIGHT_CONTROL, OFS_NINE_CONTROL, OFS_TEN_CONTROL};

    bank_state_t state;
    bank_state_t next_state;
    logic [7:0] volt_view [CHANNELS];
    logic [7:0] ctrl_view [CHANNELS];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : chan
            ldo_channel u_chan (
                .core_clk_in(core_clk_in),
                .rst_n_in(rst_n_in),
                .clk_en_in(clk_en_in),
                .wr_voltage_in(wr_in && addr_in == VOLT_OFS[g]),
                .wr_control_in(wr_in && addr_in == CTRL_OFS[g]),
                .wdata_in(wdata_in),
                .power_ok_in(power_ok_in[g]),
                .voltage_view_out(volt_view[g]),
                .control_view_out(ctrl_view[g]),
                .code_out(voltage_select_code_out[g*CODE_W +: CODE_W]),
                .enable_out(regulator_enable_out[g]),
                .discharge_out(shutdown_discharge_enable_out[g]),
                .fault_en_out(fault_interrupt_enable_out[g])
            );
        end
    endgenerate

    // unmapped addresses read zero; read data stand one cycle only
    always_comb begin
        next_state.rdata = 8'h00;
        if (rd_in) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (addr_in == VOLT_OFS[i]) begin
                    next_state.rdata = volt_view[i];
                end
                if (addr_in == CTRL_OFS[i]) begin
                    next_state.rdata = ctrl_view[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '{rdata: 8'h00};
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    assign rdata_out = state.rdata;

    a_status_read: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && rd_in && addr_in == OFS_EIGHT_CONTROL)
        |=> rdata_out[BIT_POWER_OK] == $past(power_ok_in[0]))
        else $error("power ok status read mismatch");
    a_reserved_zero: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && rd_in && addr_in == OFS_NINE_CONTROL)
        |=> rdata_out[6:3] == 4'h0)
        else $error("reserved control bits nonzero");
    a_volt_reserved: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && rd_in && addr_in == OFS_TEN_VOLTAGE)
        |=> rdata_out[7:6] == 2'h0)
        else $error("reserved voltage bits nonzero");
    a_code_write: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && wr_in && addr_in == OFS_EIGHT_VOLTAGE)
        |=> voltage_select_code_out[5:0] == $past(wdata_in[5:0]))
        else $error("voltage code not stored");
    a_enable_write: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && wr_in && addr_in == OFS_TEN_CONTROL)
        |=> regulator_enable_out[2] == $past(wdata_in[BIT_ENABLE]))
        else $error("enable bit not stored");
    a_fault_write: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && wr_in && addr_in == OFS_NINE_CONTROL)
        |=> fault_interrupt_enable_out[1] == $past(wdata_in[BIT_FAULT_EN]))
        else $error("fault enable not stored");
    a_disch_write: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && wr_in && addr_in == OFS_EIGHT_CONTROL
         && !wdata_in[BIT_ENABLE])
        |=> shutdown_discharge_enable_out[0] ==
            $past(wdata_in[BIT_DISCHARGE]))
        else $error("discharge not following control");
    a_read_once: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (clk_en_in && !rd_in) |=> rdata_out == 8'h00)
        else $error("read data held past its cycle");
endmodule

/* File: verif/ldo_control_register_bank_tb_top.sv */
// self-checking bench for the three-channel regulator register bank
`timescale 1ns/10ps
module ldo_control_register_bank_tb_top;
    import ldo_bank_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [2:0] power_ok_in = 3'h0;
    logic [7:0] rdata_out;
    logic [17:0] code;
    logic [2:0] en;
    logic [2:0] dis;
    logic [2:0] fe;
    logic [7:0] rv;
    logic [17:0] exp_code = 18'h0;
    logic [2:0] oh;
    logic [7:0] vofs [3] = '{OFS_EIGHT_VOLTAGE, OFS_NINE_VOLTAGE,
        OFS_TEN_VOLTAGE};
    logic [7:0] cofs [3] = '{OFS_EIGHT_CONTROL, OFS_NINE_CONTROL,
        OFS_TEN_CONTROL};
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #4 core_clk_in = ~core_clk_in;

    ldo_control_register_bank u_ldo_control_register_bank (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .power_ok_in(power_ok_in), .voltage_select_code_out(code),
        .regulator_enable_out(en), .shutdown_discharge_enable_out(dis),
        .fault_interrupt_enable_out(fe));

    // wide enough for the 27-bit concatenation of every output field
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask

    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ceiling well above the roughly 85 cycles the tests need
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        check({code, en, dis, fe}, 27'h0);
        for (int i = 0; i < 3; i++) begin
            rd(vofs[i]); check(rv, 8'h00);
            rd(cofs[i]); check(rv, 8'h00);
        end
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            oh = 3'b001 << i;
            exp_code[i*6 +: 6] = 6'h2a ^ 6'(i);
            wr(vofs[i], {2'b11, 6'h2a ^ 6'(i)});
            check(code, exp_code);
            rd(vofs[i]); check(rv, {2'b00, 6'h2a ^ 6'(i)});
            @(posedge core_clk_in) power_ok_in <= oh;
            wr(cofs[i], 8'hff);
            check({en, dis, fe}, {oh, 3'h0, oh});
            rd(cofs[i]); check(rv, 8'h87);
            wr(cofs[i], 8'h04);
            check({en, dis, fe}, {3'h0, oh, 3'h0});
            rd(cofs[i]); check(rv, 8'h05);
            @(posedge core_clk_in) power_ok_in <= 3'h0;
            rd(cofs[i]); check(rv, 8'h04);
            wr(cofs[i], 8'h00);
            check(dis, 3'h0);
        end
        $display("test fields done");
        wr(8'h6a, 8'hff);
        rd(8'h6a); check(rv, 8'h00);
        check({code, en, dis, fe}, {exp_code, 9'h0});
        $display("test unmapped done");
        // a frozen clock enable must swallow the strobe entirely
        @(posedge core_clk_in) clk_en_in <= 1'b0;
        wr(cofs[0], 8'h80);
        clk_en_in <= 1'b1;
        check(en, 3'h0);
        wr(cofs[0], 8'h80);
        check(en, 3'h1);
        $display("test freeze done");
        final_report();
    end
endmodule
